// ### core/bcs_burst_sram.sv
// Burst cache SRAM port: input registers, burst counter, array and data drivers
// Function
// - holds 32768 words of nine bits, fifteen address and nine data lines
// - address, data and all controls, output enable included, registered on rising edge
// - two-bit burst counter supplies low address bits after the first access
// - burst start loads counter from the two lowest address inputs
// - either processor or controller transfer start begins a burst
// - counter loads and steps the same for reads and writes
// - transfer start low abandons current burst and registers new base address
// - chip selects sampled only at base load, held until next load
// - burst advance input steps the burst in linear wrapping order
// - output enable gates data drivers after registration with its access, reads only
// - nine data lines are bidirectional tri-state
// - after a full count the burst address wraps to its start
// - read when write enable high or processor start low, write otherwise
// - output enable ignored when write enable registered low last edge without processor start
module bcs_burst_sram #(
  parameter int ADDR_WIDTH = 15,
  parameter int DATA_WIDTH = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Address and burst controls
  input wire logic [ADDR_WIDTH-1:0] address_inputs,
  input wire logic processor_transfer_start_n,
  input wire logic controller_transfer_start_n,
  input wire logic burst_advance_n,
  input wire logic write_enable_n,
  // Chip selects
  input wire logic chip_select_high,
  input wire logic chip_select_low_n,
  // Output enable, used as a registered qualifier only
  input wire logic output_enable_n,
  // Data lines split into three signals
  input wire logic [DATA_WIDTH-1:0] data_lines_in,
  output logic [DATA_WIDTH-1:0] data_lines_out,
  output logic data_lines_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Only the documented organisation is served by the array and counter
  if (ADDR_WIDTH != bcs_pkg::ADDR_WIDTH ||
      DATA_WIDTH != bcs_pkg::DATA_WIDTH) begin : g_size_check
    $error("bcs_burst_sram supports only the 32768 by 9 organisation");
  end
  // The counter must sit below the base bits of the address
  if ((1 << ADDR_WIDTH) != bcs_pkg::WORD_COUNT ||
      ADDR_WIDTH <= bcs_pkg::BURST_BITS) begin : g_depth_check
    $error("bcs_burst_sram address width does not match the word count");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  // Two stages per pin; only the second stage feeds logic
  logic [ADDR_WIDTH-1:0] addr_s1_q;
  logic [ADDR_WIDTH-1:0] addr_s2_q;
  logic [DATA_WIDTH-1:0] din_s1_q;
  logic [DATA_WIDTH-1:0] din_s2_q;
  logic tsp_s1_q;
  logic tsp_s2_q;
  logic tsc_s1_q;
  logic tsc_s2_q;
  logic adv_s1_q;
  logic adv_s2_q;
  logic we_s1_q;
  logic we_s2_q;
  logic cs_hi_s1_q;
  logic cs_hi_s2_q;
  logic cs_lo_s1_q;
  logic cs_lo_s2_q;
  logic oe_s1_q;
  logic oe_s2_q;

  // Address pair
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_s1_q <= bcs_pkg::BASE_RESET;
      addr_s2_q <= bcs_pkg::BASE_RESET;
    end else begin
      addr_s1_q <= address_inputs;
      addr_s2_q <= addr_s1_q;
    end
  end

  // Data pair, taken with the same latency as the controls
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      din_s1_q <= bcs_pkg::DATA_RESET;
      din_s2_q <= bcs_pkg::DATA_RESET;
    end else begin
      din_s1_q <= data_lines_in;
      din_s2_q <= din_s1_q;
    end
  end

  // Control pairs, reset high: the idle level of every pin but the high chip select
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tsp_s1_q <= 1'b1;
      tsp_s2_q <= 1'b1;
      tsc_s1_q <= 1'b1;
      tsc_s2_q <= 1'b1;
      adv_s1_q <= 1'b1;
      adv_s2_q <= 1'b1;
      we_s1_q <= 1'b1;
      we_s2_q <= 1'b1;
      cs_hi_s1_q <= 1'b1;
      cs_hi_s2_q <= 1'b1;
      cs_lo_s1_q <= 1'b1;
      cs_lo_s2_q <= 1'b1;
      oe_s1_q <= 1'b1;
      oe_s2_q <= 1'b1;
    end else begin
      tsp_s1_q <= processor_transfer_start_n;
      tsp_s2_q <= tsp_s1_q;
      tsc_s1_q <= controller_transfer_start_n;
      tsc_s2_q <= tsc_s1_q;
      adv_s1_q <= burst_advance_n;
      adv_s2_q <= adv_s1_q;
      we_s1_q <= write_enable_n;
      we_s2_q <= we_s1_q;
      cs_hi_s1_q <= chip_select_high;
      cs_hi_s2_q <= cs_hi_s1_q;
      cs_lo_s1_q <= chip_select_low_n;
      cs_lo_s2_q <= cs_lo_s1_q;
      oe_s1_q <= output_enable_n;
      oe_s2_q <= oe_s1_q;
    end
  end

  // Named views of the synchronised controls
  logic tsp_n;
  logic tsc_n;
  logic adv_n;
  logic we_n;
  logic cs_hi;
  logic cs_lo_n;
  logic oe_n;
  assign tsp_n = tsp_s2_q;
  assign tsc_n = tsc_s2_q;
  assign adv_n = adv_s2_q;
  assign we_n = we_s2_q;
  assign cs_hi = cs_hi_s2_q;
  assign cs_lo_n = cs_lo_s2_q;
  assign oe_n = oe_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Burst address state

  // Next burst address in linear wrapping order
  function automatic logic [1:0] bcs_next_burst(input logic [1:0] cur);
    bcs_next_burst = 2'(cur + 2'h1);
  endfunction : bcs_next_burst

  // Selection is true with the high select high and the low select low
  function automatic logic bcs_selected(input logic sel_hi, input logic sel_lo_n);
    bcs_selected = sel_hi & ~sel_lo_n;
  endfunction : bcs_selected

  // A processor start always reads; otherwise write enable decides
  function automatic logic bcs_is_read(input logic proc_n, input logic wr_n);
    bcs_is_read = ~proc_n | wr_n;
  endfunction : bcs_is_read

  // Burst state registers and their next values
  logic [ADDR_WIDTH-1:0] base_q;
  logic [ADDR_WIDTH-1:0] base_d;
  logic [1:0] burst_q;
  logic [1:0] burst_d;
  logic selected_q;
  logic selected_d;
  bcs_pkg::bcs_cycle_type cycle_q;
  bcs_pkg::bcs_cycle_type cycle_d;
  logic oe_cap_q;
  logic oe_cap_d;
  logic start;
  logic access_sel;

  // Either transfer start begins a burst
  assign start = ~tsp_n | ~tsc_n;
  // Fresh selection at a start, latched selection otherwise
  assign access_sel = start ? bcs_selected(cs_hi, cs_lo_n) : selected_q;

  // Next values of base, counter, selection and cycle kind
  always_comb begin
    base_d = base_q;
    burst_d = burst_q;
    selected_d = selected_q;
    cycle_d = bcs_pkg::BCS_IDLE;
    // Output enable travels with its access so both reach the pins together
    oe_cap_d = oe_n;
    if (start) begin
      base_d = addr_s2_q;
      burst_d = addr_s2_q[1:0];
      selected_d = bcs_selected(cs_hi, cs_lo_n);
    end else if (!adv_n) begin
      burst_d = bcs_next_burst(burst_q);
    end
    // Same counter path for both directions
    if (access_sel) begin
      if (bcs_is_read(tsp_n, we_n)) begin
        cycle_d = bcs_pkg::BCS_READ;
      end else begin
        cycle_d = bcs_pkg::BCS_WRITE;
      end
    end
  end

  // Register burst state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_q <= bcs_pkg::BASE_RESET;
      burst_q <= bcs_pkg::BURST_RESET;
      selected_q <= 1'b0;
      cycle_q <= bcs_pkg::BCS_IDLE;
      oe_cap_q <= 1'b1;
    end else begin
      base_q <= base_d;
      burst_q <= burst_d;
      selected_q <= selected_d;
      cycle_q <= cycle_d;
      oe_cap_q <= oe_cap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage access

  logic [ADDR_WIDTH-1:0] access_addr;
  logic [DATA_WIDTH-1:0] rd_word;
  logic wr_go;

  // Access address: base upper bits with counter low bits
  always_comb begin
    access_addr = {base_d[ADDR_WIDTH-1:2], burst_d};
    // Writes land at the edge that registers the write cycle
    wr_go = 1'b0;
    case (cycle_d)
      bcs_pkg::BCS_WRITE: wr_go = 1'b1;
      bcs_pkg::BCS_READ: wr_go = 1'b0;
      bcs_pkg::BCS_IDLE: wr_go = 1'b0;
      default: wr_go = 1'b0;
    endcase
  end

  // Word array, self-timed write on the clock edge
  bcs_word_array #(
    .ADDR_WIDTH(ADDR_WIDTH),
    .DATA_WIDTH(DATA_WIDTH)
  ) u_array (
    .clk(clk),
    .wr_en(wr_go),
    .wr_addr(access_addr),
    .wr_data(din_s2_q),
    .rd_addr(access_addr),
    .rd_data(rd_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data drivers

  logic [DATA_WIDTH-1:0] dout_q;
  logic [DATA_WIDTH-1:0] dout_d;
  logic oe_q;
  logic oe_d;

  // Drive only during a read with output enable low; writes and deselect float
  always_comb begin
    dout_d = rd_word;
    oe_d = 1'b0;
    // Output enable is taken from the same edge as its access
    case (cycle_q)
      bcs_pkg::BCS_READ: oe_d = ~oe_cap_q;
      bcs_pkg::BCS_WRITE: oe_d = 1'b0;
      bcs_pkg::BCS_IDLE: oe_d = 1'b0;
      default: oe_d = 1'b0;
    endcase
  end

  // Register the drivers so outputs come straight from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dout_q <= bcs_pkg::DATA_RESET;
      oe_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  // Pins come straight from the driver flops
  assign data_lines_out = dout_q;
  assign data_lines_oe = oe_q;

endmodule : bcs_burst_sram

// ### core/bcs_pkg.sv
// Package with the constants of the burst cache SRAM port
package bcs_pkg;

  // Array organisation
  localparam int ADDR_WIDTH = 15;
  localparam int DATA_WIDTH = 9;
  localparam int WORD_COUNT = 32768;
  localparam int BURST_BITS = 2;

  // Values after reset
  localparam logic [1:0] BURST_RESET = 2'h0;
  localparam logic [14:0] BASE_RESET = 15'h0000;
  localparam logic [8:0] DATA_RESET = 9'h000;

  // Cycle kind held between edges
  typedef enum logic [1:0] {
    BCS_IDLE = 2'b00,
    BCS_READ = 2'b01,
    BCS_WRITE = 2'b10
  } bcs_cycle_type;

endpackage : bcs_pkg

// ### core/bcs_word_array.sv
// Storage array of the burst cache SRAM port
module bcs_word_array #(
  parameter int ADDR_WIDTH = 15,
  parameter int DATA_WIDTH = 9
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [ADDR_WIDTH-1:0] wr_addr,
  input wire logic [DATA_WIDTH-1:0] wr_data,
  // Read side
  input wire logic [ADDR_WIDTH-1:0] rd_addr,
  output logic [DATA_WIDTH-1:0] rd_data
);

  // Word storage, one entry per address
  logic [DATA_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];

  // Synchronous write and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : bcs_word_array

// ### test/bcs_burst_sram_props.sv
// Checker for the burst cache SRAM port, bound to its top module
module bcs_burst_sram_props #(
  parameter int ADDR_WIDTH = 15,
  parameter int DATA_WIDTH = 9
) (
  // Clock, reset and controls
  input wire logic clk, sys_rst,
  input wire logic processor_transfer_start_n, controller_transfer_start_n,
  input wire logic burst_advance_n, write_enable_n, output_enable_n,
  input wire logic chip_select_high, chip_select_low_n,
  // Address and data
  input wire logic [ADDR_WIDTH-1:0] address_inputs,
  input wire logic [DATA_WIDTH-1:0] data_lines_in, data_lines_out,
  input wire logic data_lines_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Start and selection decodes
  wire start_w = !processor_transfer_start_n | !controller_transfer_start_n;
  wire sel_w = chip_select_high & !chip_select_low_n;
  // Result of each access shows four edges after its pins
  chk_desel_quiet: assert property (start_w && !sel_w |-> ##4 !data_lines_oe)
    else $error("deselected start drove data");
  chk_desel_held: assert property (start_w && !sel_w ##1 !start_w |-> ##4 !data_lines_oe)
    else $error("deselect not held");
  chk_write_quiet: assert property (processor_transfer_start_n && !write_enable_n
    |-> ##4 !data_lines_oe) else $error("write cycle drove data");
  chk_proc_read: assert property (!processor_transfer_start_n && sel_w
    && !output_enable_n |-> ##4 data_lines_oe) else $error("processor start did not read");
  chk_ctrl_read: assert property (processor_transfer_start_n
    && !controller_transfer_start_n && write_enable_n && sel_w && !output_enable_n
    |-> ##4 data_lines_oe) else $error("controller read missing");
  chk_oe_gate: assert property (data_lines_oe |-> !$past(output_enable_n, 4))
    else $error("drive without output enable");
  chk_sel_latch: assert property (start_w && sel_w ##1 (!start_w && !chip_select_high
    && write_enable_n && !output_enable_n) |-> ##4 data_lines_oe)
    else $error("selection not kept");
  chk_hold_stable: assert property (!start_w && burst_advance_n && write_enable_n
    && $past(write_enable_n) |-> ##4 (!data_lines_oe || !$past(data_lines_oe)
    || $stable(data_lines_out))) else $error("wait changed data");
  // Main scenarios
  cov_write: cover property (start_w && sel_w && !write_enable_n);
  cov_burst: cover property (data_lines_oe ##1 data_lines_oe ##1 data_lines_oe);
  cov_desel: cover property (start_w && !sel_w);
endmodule : bcs_burst_sram_props

bind bcs_burst_sram bcs_burst_sram_props #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH))
  u_props (.*);

// ### test/bcs_host_bus.sv
// Host side of the shared data lines
module bcs_host_bus (
  // Clock
  input wire logic clk,
  // Device and host drivers
  input wire logic [8:0] dev_out, host_data,
  input wire logic dev_oe, host_en,
  // Resolved line level
  output logic [8:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] last_q;
  // Released lines show the inverse of their last level
  always_ff @(posedge clk) last_q <= bus;
  // Host drives only write data; device driver wins while on
  assign bus = dev_oe ? dev_out : (host_en ? host_data : ~last_q);
endmodule : bcs_host_bus

// ### test/tb.sv
// Testbench of the burst cache SRAM port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Control codes: pstart, cstart, advance, write, sel_hi, sel_lo, read enable (all but sel_hi low)
  localparam logic [6:0] RD_P = 7'b0111100, RD_C = 7'b1011100, RD_PW = 7'b0110100;
  localparam logic [6:0] WR_C = 7'b1010101, WR_A = 7'b1100101, RD_A = 7'b1101100;
  localparam logic [6:0] HOLD = 7'b1111100, IDLE = 7'b1111101;
  logic clk = 0, sys_rst = 1, pstart_n = 1, cstart_n = 1, adv_n = 1, wr_n = 1;
  logic sel_hi = 1, sel_lo_n = 0, rd_en_n = 1, hen = 0, doe;
  logic [14:0] addr = '0;
  logic [8:0] hdata = '0, dout, bus;
  int err_total = 0, cmp_count = 0, eq[$];
  always #10 clk = ~clk;
  bcs_burst_sram DUT (.clk(clk), .sys_rst(sys_rst), .address_inputs(addr),
    .processor_transfer_start_n(pstart_n), .controller_transfer_start_n(cstart_n),
    .burst_advance_n(adv_n), .write_enable_n(wr_n), .chip_select_high(sel_hi),
    .chip_select_low_n(sel_lo_n), .output_enable_n(rd_en_n), .data_lines_in(bus),
    .data_lines_out(dout), .data_lines_oe(doe));
  bcs_host_bus host (.clk(clk), .dev_out(dout), .dev_oe(doe), .host_data(hdata),
    .host_en(hen), .bus(bus));
  // Compare driver state and data against the expected result
  task automatic cmp(logic eo, logic [8:0] ed);
    cmp_count++;
    if (doe !== eo || (eo && dout !== ed)) begin
      err_total++;
      $display("BAD %0t oe %b data %h", $time, doe, dout);
    end
  endtask : cmp
  // One bus cycle; judges the access whose result appeared after the last edge
  task automatic step(logic [6:0] c, logic [14:0] a, logic [8:0] d, int e);
    int x;
    @(negedge clk);
    if (eq.size() == 4) begin
      x = eq.pop_front();
      if (x != -1) cmp(x >= 0, 9'(x));
    end
    {pstart_n, cstart_n, adv_n, wr_n, sel_hi, sel_lo_n, rd_en_n} = c;
    hen = !c[3];
    addr = a;
    hdata = d;
    eq.push_back(e);
  endtask : step
  // Burst write from a controller start, pins garbage after the base
  task automatic t_write;
    step(WR_C, 15'h1232, 9'h1a5, -2);
    step(WR_A, 15'h7fff, 9'h05a, -2);
    step(WR_A, 15'h7fff, 9'h133, -2);
    step(WR_A, 15'h7fff, 9'h0cc, -2);
  endtask : t_write
  // Burst read with a wait, one wrap and restarts mid burst
  task automatic t_read;
    step(RD_P, 15'h1232, 9'h000, 9'h1a5);
    step(RD_A, 15'h7fff, 9'h000, 9'h05a);
    step(HOLD, 15'h7fff, 9'h000, 9'h05a);
    step(RD_A, 15'h7fff, 9'h000, 9'h133);
    step(RD_A, 15'h7fff, 9'h000, 9'h0cc);
    step(RD_A, 15'h7fff, 9'h000, 9'h1a5);
    step(RD_C, 15'h1230, 9'h000, 9'h133);
    step(RD_PW, 15'h1231, 9'h000, 9'h0cc);
  endtask : t_read
  // Deselect by either select, latch of selection, output enable gating
  task automatic t_desel;
    step(7'b0111000, 15'h1232, 9'h000, -2);
    step(HOLD, 15'h1232, 9'h000, -2);
    step(7'b1011110, 15'h1232, 9'h000, -2);
    step(RD_P, 15'h1230, 9'h000, 9'h133);
    step(7'b1101010, 15'h0000, 9'h000, 9'h0cc);
    step(IDLE, 15'h0000, 9'h000, -2);
    step(HOLD, 15'h0000, 9'h000, 9'h0cc);
  endtask : t_desel
  // Print counts and verdict, then stop
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // Watchdog on the whole run
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) sys_rst = 0;
    step(IDLE, 15'h0000, 9'h000, -1);
    t_write();
    t_read();
    t_desel();
    repeat (5) step(IDLE, 15'h0000, 9'h000, -2);
    end_of_test();
  end
endmodule : tb
